//--- rtl/rx_filter_cs.sv
// Receive filter setup, carrier sense and loop freeze control with Avalon-MM registers
`timescale 1ns/1ns
`include "rx_filter_cs_map.svh"
module rx_filter_cs
  import rx_filter_cs_pkg::*;
#(
  parameter int SAMPLE_W = 12
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic filter_clk_tick,
  input wire logic adc_clk_tick,
  input wire logic dec_base_tick,
  input wire logic adc_valid,
  input wire logic [SAMPLE_W-1:0] adc_data,
  input wire logic mag_valid,
  input wire logic mag_at_or_above,
  input wire logic gain_changed,
  input wire logic freeze_event,
  output logic filter_bypass,
  output logic [1:0] decimator_input_shift,
  output logic decimation_clk,
  output logic dec_valid,
  output logic [SAMPLE_W+2:0] dec_data,
  output logic lock_pin,
  output logic loops_frozen
);
  // Register file and bus handshake
  bus_state_e bus_reg;
  bus_state_e bus_next;
  logic [7:0] filter_cfg_reg;
  logic [7:0] filter_cfg_next;
  logic [7:0] cs_hold_cfg_reg;
  logic [7:0] cs_hold_cfg_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic wait_reg;
  logic wait_next;
  logic req;
  logic [7:0] status_val;

  // Decimation and shift path
  logic [2:0] div_cnt_reg;
  logic [2:0] div_cnt_next;
  logic dclk_reg;
  logic dclk_next;
  logic dvalid_reg;
  logic dvalid_next;
  logic [SAMPLE_W+2:0] ddata_reg;
  logic [SAMPLE_W+2:0] ddata_next;
  logic bypass_reg;
  logic bypass_next;
  logic [1:0] shift_reg;
  logic [1:0] shift_next;

  // Carrier sense
  logic cs_reg;
  logic cs_next;
  logic [1:0] above_cnt_reg;
  logic [1:0] above_cnt_next;
  logic below_cnt_reg;
  logic below_cnt_next;

  // Loop freeze
  logic frozen_reg;
  logic frozen_next;
  logic [2:0] wait_code;
  logic [1:0] xfrz_code;

  freeze_if gain_fz ();
  freeze_if extra_fz ();

  assign req = avs_read | avs_write;
  assign wait_code = cs_hold_cfg_reg[`WAIT_HI:`WAIT_LO];
  assign xfrz_code = cs_hold_cfg_reg[`XFRZ_HI:`XFRZ_LO];
  assign status_val = {6'h00, frozen_reg, cs_reg};

  always_comb begin
    bus_next = bus_reg;
    filter_cfg_next = filter_cfg_reg;
    cs_hold_cfg_next = cs_hold_cfg_reg;
    rdata_next = rdata_reg;
    wait_next = 1'b1;
    case (bus_reg)
      bus_idle_st: begin
        if (req) begin
          // Answer one cycle after the request is seen
          bus_next = bus_ack_st;
          wait_next = 1'b0;
          case (avs_address)
            `FILTER_CFG_ADDR: begin
              rdata_next = {24'h000000, filter_cfg_reg};
            end
            `CS_HOLD_CFG_ADDR: begin
              rdata_next = {24'h000000, cs_hold_cfg_reg};
            end
            `STATUS_ADDR: begin
              rdata_next = {24'h000000, status_val};
            end
            default: begin
              rdata_next = 32'h00000000;
            end
          endcase
        end
      end
      bus_ack_st: begin
        // Write lands on the edge where waitrequest is seen low
        bus_next = bus_idle_st;
        if (avs_write) begin
          case (avs_address)
            `FILTER_CFG_ADDR: begin
              // Reserved bits are dropped, so they read as zero
              filter_cfg_next = avs_writedata[7:0] & `FILTER_CFG_MASK; // see RULE_16
            end
            `CS_HOLD_CFG_ADDR: begin
              cs_hold_cfg_next = avs_writedata[7:0];
            end
            default: begin
              filter_cfg_next = filter_cfg_reg;
            end
          endcase
        end
      end
      default: begin
        bus_next = bus_idle_st;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      bus_reg <= bus_idle_st;
      filter_cfg_reg <= `FILTER_CFG_RESET;
      cs_hold_cfg_reg <= `CS_HOLD_CFG_RESET;
      rdata_reg <= 32'h00000000;
      wait_reg <= 1'b1;
    end else begin
      bus_reg <= bus_next;
      filter_cfg_reg <= filter_cfg_next;
      cs_hold_cfg_reg <= cs_hold_cfg_next;
      rdata_reg <= rdata_next;
      wait_reg <= wait_next;
    end
  end

  // Decimation clock, input shift and analog filter bypass
  always_comb begin
    div_cnt_next = div_cnt_reg;
    dclk_next = 1'b0;
    if (dec_base_tick) begin
      if (div_cnt_reg >= filter_cfg_reg[`DIV_HI:`DIV_LO]) begin
        // Divide by field value plus one
        div_cnt_next = 3'h0; // see RULE_05
        dclk_next = 1'b1; // see RULE_05
      end else begin
        div_cnt_next = div_cnt_reg + 3'h1;
      end
    end
    bypass_next = filter_cfg_reg[`BYPASS_BIT]; // see RULE_01
    shift_next = filter_cfg_reg[`SHIFT_HI:`SHIFT_LO];
    dvalid_next = adc_valid;
    ddata_next = ddata_reg;
    if (adc_valid) begin
      // Output is three bits wider so the largest shift never loses bits
      // Registered field used, so data matches the shift shown in the cycle the sample arrived
      ddata_next = {3'h0, adc_data} << shift_reg; // see RULE_03
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      div_cnt_reg <= 3'h0;
      dclk_reg <= 1'b0;
      bypass_reg <= 1'b0;
      shift_reg <= 2'h0;
      dvalid_reg <= 1'b0;
      ddata_reg <= '0;
    end else begin
      div_cnt_reg <= div_cnt_next;
      dclk_reg <= dclk_next;
      bypass_reg <= bypass_next;
      shift_reg <= shift_next;
      dvalid_reg <= dvalid_next;
      ddata_reg <= ddata_next;
    end
  end

  // Carrier sense runs regardless of the freeze state
  always_comb begin
    cs_next = cs_reg;
    above_cnt_next = above_cnt_reg;
    below_cnt_next = below_cnt_reg;
    if (mag_valid) begin // see RULE_17
      if (mag_at_or_above) begin
        below_cnt_next = 1'b0;
        if (!cs_reg) begin
          if (above_cnt_reg >= cs_hold_cfg_reg[`CS_SET_HI:`CS_SET_LO]) begin
            cs_next = 1'b1; // see RULE_06
            above_cnt_next = 2'h0;
          end else begin
            above_cnt_next = above_cnt_reg + 2'h1;
          end
        end
      end else begin
        above_cnt_next = 2'h0;
        if (cs_reg) begin
          if (!cs_hold_cfg_reg[`CS_CLR_BIT] || below_cnt_reg) begin
            cs_next = 1'b0; // see RULE_08
            below_cnt_next = 1'b0;
          end else begin
            below_cnt_next = 1'b1;
          end
        end
      end
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cs_reg <= 1'b0;
      above_cnt_reg <= 2'h0;
      below_cnt_reg <= 1'b0;
    end else begin
      cs_reg <= cs_next;
      above_cnt_reg <= above_cnt_next;
      below_cnt_reg <= below_cnt_next;
    end
  end

  // Gain change freeze on filter clock periods
  always_comb begin
    gain_fz.start = gain_changed; // see RULE_10
    gain_fz.tick = filter_clk_tick;
    gain_fz.hold_forever = (wait_code == `WAIT_HOLD_CODE); // see RULE_12
    case (wait_code) // see RULE_11
      3'h0: gain_fz.len = `WAIT_LEN_0;
      3'h1: gain_fz.len = `WAIT_LEN_1;
      3'h2: gain_fz.len = `WAIT_LEN_2;
      3'h3: gain_fz.len = `WAIT_LEN_3;
      3'h4: gain_fz.len = `WAIT_LEN_4;
      3'h5: gain_fz.len = `WAIT_LEN_5;
      3'h6: gain_fz.len = `WAIT_LEN_6;
      default: gain_fz.len = `WAIT_LEN_6;
    endcase
  end

  // Extra freeze on ADC clock periods; tick rate is set outside, nominally ADC_CLK_NOMINAL_HZ
  always_comb begin
    extra_fz.start = freeze_event; // see RULE_10
    extra_fz.tick = adc_clk_tick; // see RULE_15
    extra_fz.hold_forever = 1'b0;
    case (xfrz_code) // see RULE_13
      2'h0: extra_fz.len = `XFRZ_LEN_0;
      2'h1: extra_fz.len = `XFRZ_LEN_1;
      2'h2: extra_fz.len = `XFRZ_LEN_2;
      default: extra_fz.len = `XFRZ_LEN_3;
    endcase
  end

  freeze_timer u_gain_timer (
    .mclk(mclk),
    .rstn(rstn),
    .fz(gain_fz.timer)
  );

  freeze_timer u_extra_timer (
    .mclk(mclk),
    .rstn(rstn),
    .fz(extra_fz.timer)
  );

  always_comb begin
    frozen_next = gain_fz.active | extra_fz.active; // see RULE_10
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      frozen_reg <= 1'b0;
    end else begin
      frozen_reg <= frozen_next;
    end
  end

  assign avs_readdata = rdata_reg;
  assign avs_waitrequest = wait_reg;
  assign filter_bypass = bypass_reg;
  assign decimator_input_shift = shift_reg;
  assign decimation_clk = dclk_reg;
  assign dec_valid = dvalid_reg;
  assign dec_data = ddata_reg;
  // Pin mirrors the carrier sense flop directly
  assign lock_pin = cs_reg; // see RULE_07
  assign loops_frozen = frozen_reg;
endmodule : rx_filter_cs

//--- rtl/rx_filter_cs_map.svh
// Register map, field positions, reset values and timing constants of the receive control block
// How it works
// RULE_01: Bypass bit set routes receive path around the analog anti-alias filter.
// RULE_02: Software clears bypass below the baud threshold, sets it at or above.
// RULE_03: Two-bit field gives zero to three extra shifts of decimator input.
// RULE_04: Software uses shift zero for divisor field up to one, else one.
// RULE_05: Three-bit divisor field divides the decimation clock by value plus one.
// RULE_06: Carrier sense sets after one to four consecutive samples at or above level.
// RULE_07: Carrier sense is driven on the lock status pin.
// RULE_08: Carrier sense clears after one, or two if bit set, samples below level.
// RULE_09: Software sets the clear-count bit to one against noise.
// RULE_10: Loops freeze after gain change from channel switch, lock loss or power-up.
// RULE_11: Gain freeze codes zero to six give 16 to 48 filter clock periods.
// RULE_12: Gain freeze code seven holds loop levels frozen with no timeout.
// RULE_13: Extra freeze of 16, 32, 64 or 128 ADC clocks after those events.
// RULE_14: Software sets receive deviation to half or equal transmit deviation.
// RULE_15: Extra freeze is timed by the ADC clock, four times the IF.
// RULE_16: Reserved filter bits are written zero and ignored by the device.
// RULE_17: Carrier sense counters keep running on samples while loops are frozen.
`ifndef RX_FILTER_CS_MAP_SVH
`define RX_FILTER_CS_MAP_SVH
`define FILTER_CFG_INDEX 8'h10
`define CS_HOLD_CFG_INDEX 8'h11
`define STATUS_INDEX 8'h18
`define FILTER_CFG_ADDR 8'h40
`define CS_HOLD_CFG_ADDR 8'h44
`define STATUS_ADDR 8'h60
`define FILTER_CFG_RESET 8'h00
`define CS_HOLD_CFG_RESET 8'h65
`define FILTER_CFG_MASK 8'hE7
`define BYPASS_BIT 7
`define SHIFT_HI 6
`define SHIFT_LO 5
`define DIV_HI 2
`define DIV_LO 0
`define CS_SET_HI 7
`define CS_SET_LO 6
`define CS_CLR_BIT 5
`define WAIT_HI 4
`define WAIT_LO 2
`define XFRZ_HI 1
`define XFRZ_LO 0
`define WAIT_HOLD_CODE 3'h7
`define WAIT_LEN_0 8'h10
`define WAIT_LEN_1 8'h14
`define WAIT_LEN_2 8'h18
`define WAIT_LEN_3 8'h1C
`define WAIT_LEN_4 8'h20
`define WAIT_LEN_5 8'h28
`define WAIT_LEN_6 8'h30
`define XFRZ_LEN_0 8'h10
`define XFRZ_LEN_1 8'h20
`define XFRZ_LEN_2 8'h40
`define XFRZ_LEN_3 8'h80
`define ADC_CLK_NOMINAL_HZ 1228800
`endif

//--- rtl/rx_filter_cs_pkg.sv
// Types shared by the receive control block
package rx_filter_cs_pkg;
  typedef enum logic {
    bus_idle_st = 1'b0,
    bus_ack_st = 1'b1
  } bus_state_e;
  typedef enum logic [1:0] {
    tmr_idle_st = 2'b00,
    tmr_run_st = 2'b01,
    tmr_hold_st = 2'b10
  } tmr_state_e;
  typedef logic [7:0] count_t;
endpackage : rx_filter_cs_pkg

//--- rtl/freeze_if.sv
// Link between the control logic and one freeze timer
`timescale 1ns/1ns
interface freeze_if;
  logic start;
  logic tick;
  logic [7:0] len;
  logic hold_forever;
  logic active;
  modport ctrl (output start, output tick, output len, output hold_forever, input active);
  modport timer (input start, input tick, input len, input hold_forever, output active);
endinterface : freeze_if

//--- rtl/freeze_timer.sv
// Countdown timer that holds the loop freeze for a set number of ticks
`timescale 1ns/1ns
module freeze_timer
  import rx_filter_cs_pkg::*;
(
  input wire logic mclk,
  input wire logic rstn,
  freeze_if.timer fz
);
  tmr_state_e state_reg;
  tmr_state_e state_next;
  count_t cnt_reg;
  count_t cnt_next;
  logic active_reg;
  logic active_next;

  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    if (fz.hold_forever) begin
      state_next = tmr_hold_st;
    end else begin
      case (state_reg)
        tmr_idle_st: begin
          if (fz.start) begin
            state_next = tmr_run_st;
            cnt_next = fz.len;
          end
        end
        tmr_run_st: begin
          if (fz.start) begin
            // Fresh event restarts the full length
            cnt_next = fz.len;
          end else if (fz.tick) begin
            cnt_next = cnt_reg - 8'h01;
            if (cnt_reg <= 8'h01) begin
              state_next = tmr_idle_st;
            end
          end
        end
        tmr_hold_st: begin
          state_next = tmr_idle_st;
        end
        default: begin
          state_next = tmr_idle_st;
        end
      endcase
    end
    active_next = (state_next != tmr_idle_st);
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= tmr_idle_st;
      cnt_reg <= 8'h00;
      active_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      active_reg <= active_next;
    end
  end

  assign fz.active = active_reg;
endmodule : freeze_timer

//--- testbench/rx_filter_cs_props.sv
// Concurrent checks on the ports of the receive control block
`timescale 1ns/1ns
`include "rx_filter_cs_map.svh"
module rx_filter_cs_props #(
  parameter int SAMPLE_W = 12
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic dec_base_tick,
  input wire logic adc_valid,
  input wire logic [SAMPLE_W-1:0] adc_data,
  input wire logic mag_valid,
  input wire logic mag_at_or_above,
  input wire logic gain_changed,
  input wire logic freeze_event,
  input wire logic filter_bypass,
  input wire logic [1:0] decimator_input_shift,
  input wire logic decimation_clk,
  input wire logic dec_valid,
  input wire logic [SAMPLE_W+2:0] dec_data,
  input wire logic lock_pin,
  input wire logic loops_frozen
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  wait_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("request not answered after one cycle");
  read_upper_a: assert property (!avs_waitrequest |-> avs_readdata[31:8] == 24'h000000)
    else $error("upper read data not zero");
  cfg_out_a: assert property (avs_write && !avs_waitrequest && avs_address == `FILTER_CFG_ADDR |-> ##2
    filter_bypass == $past(avs_writedata[7], 2) && decimator_input_shift == $past(avs_writedata[6:5], 2))
    else $error("filter outputs do not follow written value");
  dec_out_a: assert property (adc_valid |=> dec_valid &&
    dec_data == ((SAMPLE_W+3)'($past(adc_data)) << $past(decimator_input_shift)))
    else $error("decimator input shift wrong");
  lock_rise_a: assert property ($rose(lock_pin) |-> $past(mag_valid && mag_at_or_above))
    else $error("carrier sense set without a sample above level");
  lock_fall_a: assert property ($fell(lock_pin) |-> $past(mag_valid && !mag_at_or_above))
    else $error("carrier sense cleared without a sample below level");
  frz_start_a: assert property (gain_changed || freeze_event |-> ##2 loops_frozen)
    else $error("loops not frozen after event");
  dclk_tick_a: assert property (decimation_clk |-> $past(dec_base_tick))
    else $error("decimation clock without base tick");
endmodule : rx_filter_cs_props
bind rx_filter_cs rx_filter_cs_props #(.SAMPLE_W(SAMPLE_W)) props_u (.mclk(mclk), .rstn(rstn),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .dec_base_tick(dec_base_tick),
  .adc_valid(adc_valid), .adc_data(adc_data), .mag_valid(mag_valid), .mag_at_or_above(mag_at_or_above),
  .gain_changed(gain_changed), .freeze_event(freeze_event), .filter_bypass(filter_bypass),
  .decimator_input_shift(decimator_input_shift), .decimation_clk(decimation_clk), .dec_valid(dec_valid),
  .dec_data(dec_data), .lock_pin(lock_pin), .loops_frozen(loops_frozen));

//--- testbench/cs_host_watch.sv
// Host side watcher counting carrier sense rises on the lock pin
`timescale 1ns/1ns
module cs_host_watch (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic lock_pin,
  output int rises
);
  logic last_reg;
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      last_reg <= 1'b0;
      rises <= 0;
    end else begin
      last_reg <= lock_pin;
      if (lock_pin === 1'b1 && last_reg === 1'b0) rises <= rises + 1;
    end
  end
endmodule : cs_host_watch

//--- testbench/tb_rx_filter_cs.sv
// Register, decimation, carrier sense and freeze tests of the receive control block
`timescale 1ns/1ns
`include "rx_filter_cs_map.svh"
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin n_mismatch++; \
  $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module tb_rx_filter_cs;
  logic mclk = 1'b0, rstn = 1'b0, avs_read = 1'b0, avs_write = 1'b0, adc_valid = 1'b0, mag_valid = 1'b0;
  logic filter_clk_tick = 1'b0, adc_clk_tick = 1'b0, dec_base_tick = 1'b0, mag_at_or_above = 1'b0;
  logic gain_changed = 1'b0, freeze_event = 1'b0;
  logic [7:0] avs_address = 8'h00, q;
  logic [31:0] avs_writedata = 32'h0, avs_readdata;
  logic [11:0] adc_data = 12'h000;
  logic avs_waitrequest, filter_bypass, decimation_clk, dec_valid, lock_pin, loops_frozen;
  logic [1:0] decimator_input_shift;
  logic [14:0] dec_data;
  int n_mismatch = 0, cmp_count = 0, rises;
  int glen[7] = '{16, 20, 24, 28, 32, 40, 48};
  int xlen[4] = '{16, 32, 64, 128};
  always #50 mclk = ~mclk;
  rx_filter_cs #(.SAMPLE_W(12)) dut_u (.mclk(mclk), .rstn(rstn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .filter_clk_tick(filter_clk_tick), .adc_clk_tick(adc_clk_tick),
    .dec_base_tick(dec_base_tick), .adc_valid(adc_valid), .adc_data(adc_data), .mag_valid(mag_valid),
    .mag_at_or_above(mag_at_or_above), .gain_changed(gain_changed), .freeze_event(freeze_event),
    .filter_bypass(filter_bypass), .decimator_input_shift(decimator_input_shift),
    .decimation_clk(decimation_clk), .dec_valid(dec_valid), .dec_data(dec_data), .lock_pin(lock_pin),
    .loops_frozen(loops_frozen));
  cs_host_watch host_u (.mclk(mclk), .rstn(rstn), .lock_pin(lock_pin), .rises(rises));
  task automatic final_report;
    $display("Mismatches %0d in %0d comparisons", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : final_report
  // Entered and left just after a rising edge; a wait of 50 cycles counts as a fault
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    int i;
    i = 0;
    avs_address <= a;
    avs_writedata <= {24'h000000, d};
    avs_write <= w;
    avs_read <= !w;
    do begin
      @(posedge mclk);
      i++;
    end while (avs_waitrequest !== 1'b0 && i < 50);
    if (i >= 50) n_mismatch++;
    q = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    // Idle edge so a following call never reassigns the strobes in the same step
    @(posedge mclk);
  endtask : bus
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    `CHK("readdata", e, q)
  endtask : rdc
  task automatic smp(input logic above, input logic e);
    mag_valid <= 1'b1;
    mag_at_or_above <= above;
    @(posedge mclk);
    mag_valid <= 1'b0;
    @(posedge mclk);
    @(negedge mclk);
    `CHK("lock_pin", e, lock_pin)
    @(posedge mclk);
  endtask : smp
  // Ticks every cycle from the edge after the event, so frozen cycles equal the length
  task automatic frz(input logic ext, input int n);
    int cnt;
    cnt = 0;
    freeze_event <= ext;
    gain_changed <= !ext;
    @(posedge mclk);
    freeze_event <= 1'b0;
    gain_changed <= 1'b0;
    filter_clk_tick <= 1'b1;
    adc_clk_tick <= 1'b1;
    repeat (n + 12) begin
      @(negedge mclk);
      if (loops_frozen === 1'b1) cnt++;
      @(posedge mclk);
    end
    filter_clk_tick <= 1'b0;
    adc_clk_tick <= 1'b0;
    `CHK("frozen_len", n, cnt)
  endtask : frz
  // Whole divisor periods of ticks, so the divider always starts and ends at phase zero
  task automatic dec(input logic [2:0] d);
    int cnt;
    cnt = 0;
    bus(1'b1, `FILTER_CFG_ADDR, {1'b0, (d > 3'h1) ? 2'h1 : 2'h0, 2'h0, d});
    dec_base_tick <= 1'b1;
    for (int i = 0; i < 8 * (d + 1) + 2; i++) begin
      @(negedge mclk);
      if (decimation_clk === 1'b1) cnt++;
      @(posedge mclk);
      if (i == 8 * (d + 1) - 1) dec_base_tick <= 1'b0;
    end
    `CHK("dec_pulses", 8, cnt)
  endtask : dec
  initial begin
    repeat (8) @(posedge mclk);
    rstn <= 1'b1;
    @(posedge mclk);
    rdc(`FILTER_CFG_ADDR, `FILTER_CFG_RESET);
    rdc(`CS_HOLD_CFG_ADDR, `CS_HOLD_CFG_RESET);
    bus(1'b1, 8'h48, 8'hFF);
    rdc(8'h48, 8'h00);
    bus(1'b1, `FILTER_CFG_ADDR, 8'hFF);
    rdc(`FILTER_CFG_ADDR, `FILTER_CFG_MASK);
    `CHK("bypass", 1'b1, filter_bypass)
    `CHK("shift", 2'h3, decimator_input_shift)
    // Receive deviation lives outside this block, so no field here is written
    dec(3'h0);
    dec(3'h2);
    dec(3'h7);
    `CHK("bypass", 1'b0, filter_bypass)
    adc_data <= 12'hABC;
    adc_valid <= 1'b1;
    @(posedge mclk);
    adc_valid <= 1'b0;
    @(negedge mclk);
    `CHK("dec_data", 15'h1578, dec_data)
    @(posedge mclk);
    for (int n = 0; n < 4; n++) begin
      bus(1'b1, `CS_HOLD_CFG_ADDR, {n[1:0], n[0], 5'h00});
      smp(1'b1, n == 0);
      smp(1'b0, 1'b0);
      for (int k = 0; k <= n; k++) smp(1'b1, k == n);
      smp(1'b0, n[0]);
      if (n[0]) smp(1'b0, 1'b0);
    end
    for (int c = 0; c < 7; c++) begin
      bus(1'b1, `CS_HOLD_CFG_ADDR, {3'h1, c[2:0], 2'h0});
      frz(1'b0, glen[c]);
    end
    for (int c = 0; c < 4; c++) begin
      bus(1'b1, `CS_HOLD_CFG_ADDR, {6'h08, c[1:0]});
      frz(1'b1, xlen[c]);
    end
    bus(1'b1, `CS_HOLD_CFG_ADDR, 8'h3C);
    repeat (4) @(posedge mclk);
    `CHK("frozen", 1'b1, loops_frozen)
    smp(1'b1, 1'b1);
    rdc(`STATUS_ADDR, 8'h03);
    bus(1'b1, `STATUS_ADDR, 8'h00);
    rdc(`STATUS_ADDR, 8'h03);
    bus(1'b1, `CS_HOLD_CFG_ADDR, 8'h20);
    repeat (5) @(posedge mclk);
    `CHK("frozen", 1'b0, loops_frozen)
    `CHK("host_rises", 6, rises)
    final_report();
  end
  initial begin
    #3000000;
    n_mismatch++;
    final_report();
  end
endmodule : tb_rx_filter_cs
